// *** hdl/coef_block_addr.sv ***
// block addressing and word sequencing for the per-channel coefficient memory
`timescale 1ns/100ps
`include "coef_addr_params.svh"
module coef_block_addr
    import coef_addr_pkg::*;
#(
    parameter int DATA_W = `COEF_DATA_W
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // command from the host interface decoder
    input wire logic cmd_valid_in,
    input wire logic cmd_write_in,
    input wire logic [`COEF_BLK_W-1:0] cmd_block_in,
    output logic cmd_ready_out,
    output logic cmd_error_out,
    // one data word per step, host order high to low
    input wire logic word_valid_in,
    input wire logic [DATA_W-1:0] word_wdata_in,
    output logic word_ready_out,
    output logic [DATA_W-1:0] word_rdata_out,
    output logic [`COEF_IDX_W-1:0] word_index_out,
    output logic [`COEF_ADDR_W-1:0] word_addr_out,
    output logic busy_out,
    output logic done_out,
    // region currently addressed
    output coef_region_t region_out
);

    // address of a word: block number in the upper bits, word index below
    function automatic logic [`COEF_ADDR_W-1:0] word_addr_of(
        input logic [`COEF_BLK_W-1:0] blk,
        input logic [`COEF_IDX_W-1:0] idx
    );
        word_addr_of = {blk, idx};
    endfunction

    // decode of the region that a six-bit address falls into
    function automatic coef_region_t region_of(input logic [`COEF_ADDR_W-1:0] a);
        logic [`COEF_BLK_W-1:0] b;
        logic [`COEF_IDX_W-1:0] i;
        b = a[`COEF_ADDR_W-1:`COEF_IDX_W];
        i = a[`COEF_IDX_W-1:0];
        case (b)
            `BLK_IMPEDANCE: begin
                region_of = region_impedance_filter_coeffs;
            end
            `BLK_ECHO: begin
                region_of = region_echo_filter_coeffs;
            end
            `BLK_GAIN_TONE: begin
                // lower half input gain, upper half tone pairs with frequency first
                if (i < `IDX_TONE_BASE) begin
                    region_of = region_input_gain_coeffs;
                end else begin
                    case (i[1:0])
                        2'h0: region_of = region_tone0_freq;
                        2'h1: region_of = region_tone0_amp;
                        2'h2: region_of = region_tone1_freq;
                        default: region_of = region_tone1_amp;
                    endcase
                end
            end
            `BLK_TRANSMIT: begin
                // upper half gain, lower half frequency response
                if (i > `IDX_RESP_TOP) begin
                    region_of = region_transmit_gain_coeffs;
                end else begin
                    region_of = region_transmit_response_coeffs;
                end
            end
            `BLK_RECEIVE: begin
                // one block number reaches receive gain and receive response together
                if (i > `IDX_RESP_TOP) begin
                    region_of = region_receive_gain_coeffs;
                end else begin
                    region_of = region_receive_response_coeffs;
                end
            end
            default: begin
                region_of = region_none;
            end
        endcase
    endfunction

    // coefficient storage, forty words addressed by the six-bit word address
    logic [DATA_W-1:0] mem_ff [`COEF_WORDS];
    // sequencer state and the walk in hand
    walk_state_t state_ff, nxt_state;
    logic [`COEF_BLK_W-1:0] blk_ff, nxt_blk;
    logic [`COEF_IDX_W-1:0] idx_ff, nxt_idx;
    logic wr_ff, nxt_wr;
    // registered status and data outputs
    logic done_ff, nxt_done;
    logic err_ff, nxt_err;
    logic [DATA_W-1:0] rdata_ff;
    coef_region_t region_ff, nxt_region;

    // address of the word in hand and of the word that the next edge brings
    wire logic [`COEF_ADDR_W-1:0] cur_addr = word_addr_of(blk_ff, idx_ff);
    wire logic [`COEF_ADDR_W-1:0] ahead_addr = word_addr_of(nxt_blk, nxt_idx);

    // handshake decoding; blocks five to seven are refused with an error pulse
    wire logic blk_ok = cmd_block_in < `COEF_BLOCKS;
    wire logic idle = state_ff == st_idle;
    wire logic walking = state_ff == st_walk;
    wire logic step = walking && word_valid_in;
    wire logic last = idx_ff == `COEF_IDX_LAST;
    wire logic start = idle && cmd_valid_in && blk_ok;
    wire logic refuse = idle && cmd_valid_in && !blk_ok;
    wire logic step_wr = step && wr_ff;

    // handshake outputs straight from state, data outputs from registers
    assign cmd_ready_out = idle;
    assign word_ready_out = walking;
    assign busy_out = walking;
    assign word_index_out = idx_ff;
    assign word_addr_out = cur_addr;
    assign region_out = region_ff;
    assign done_out = done_ff;
    assign cmd_error_out = err_ff;
    assign word_rdata_out = rdata_ff;

    // sequencer: start at the top word and count down each step
    always_comb begin
        nxt_state = state_ff;
        nxt_blk = blk_ff;
        nxt_idx = idx_ff;
        nxt_wr = wr_ff;
        case (state_ff)
            st_idle: begin
                if (start) begin
                    nxt_state = st_walk;
                    nxt_blk = cmd_block_in;
                    nxt_idx = `COEF_IDX_FIRST;
                    nxt_wr = cmd_write_in;
                end
            end
            st_walk: begin
                // a stalled step leaves the index where it is
                if (step) begin
                    nxt_idx = idx_ff - 3'h1;
                    if (last) begin
                        nxt_state = st_idle;
                    end
                end
            end
            default: begin
                nxt_state = st_idle;
            end
        endcase
    end

    // one-cycle pulses, and the region of the word that the next edge brings
    always_comb begin
        nxt_done = step && last;
        nxt_err = refuse;
        nxt_region = region_none;
        if (nxt_state == st_walk) begin
            nxt_region = region_of(ahead_addr);
        end
    end

    // sequencer state
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state_ff <= st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // block number, word index and direction of the walk in hand
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            blk_ff <= `COEF_BLK_RESET;
            idx_ff <= `COEF_IDX_RESET;
            wr_ff <= 1'b0;
        end else begin
            blk_ff <= nxt_blk;
            idx_ff <= nxt_idx;
            wr_ff <= nxt_wr;
        end
    end

    // done and error pulses, and the region of the addressed word
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            region_ff <= region_none;
        end else begin
            done_ff <= nxt_done;
            err_ff <= nxt_err;
            region_ff <= nxt_region;
        end
    end

    // read data fetched one edge early so that it stands together with its address
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rdata_ff <= '0;
        end else if (start || step) begin
            rdata_ff <= mem_ff[ahead_addr];
        end
    end

    // one select line per coefficient word, high on a write step at that word
    wire logic [`COEF_WORDS-1:0] word_sel;
    generate
        for (genvar w = 0; w < `COEF_WORDS; w++) begin : g_sel
            assign word_sel[w] = step_wr && (cur_addr == `COEF_ADDR_W'(w));
        end
    endgenerate

    // coefficient words written in walk order; storage has no reset
    always_ff @(posedge core_clk_in) begin
        for (int k = 0; k < `COEF_WORDS; k++) begin
            if (word_sel[k]) begin
                mem_ff[k] <= word_wdata_in;
            end
        end
    end

endmodule // coef_block_addr

// *** include/coef_addr_params.svh ***
// constants for the coefficient memory block addressing logic
// Operation
// - coefficient memory holds forty words in five blocks of eight words
// - word address is six bits: block number high, word index low
// - host command gives only the three-bit block number; device adds word index
// - one command walks all eight words, word index counting 111 down to 000
// - block 100 covers receive gain words 39-36 and receive response words 35-32
// - blocks 000 to 100 map impedance, echo, input gain/tone, transmit, receive
// - block 010: words 16-19 input gain, 20-23 tone frequency then amplitude
`ifndef COEF_ADDR_PARAMS_SVH
`define COEF_ADDR_PARAMS_SVH
`define COEF_WORDS 40
`define COEF_BLOCKS 5
`define COEF_BLOCK_WORDS 8
`define COEF_ADDR_W 6
`define COEF_BLK_W 3
`define COEF_IDX_W 3
`define COEF_DATA_W 16
`define COEF_IDX_FIRST 3'h7
`define COEF_IDX_LAST 3'h0
`define COEF_BLK_RESET 3'h0
`define COEF_IDX_RESET 3'h0
`define BLK_IMPEDANCE 3'h0
`define BLK_ECHO 3'h1
`define BLK_GAIN_TONE 3'h2
`define BLK_TRANSMIT 3'h3
`define BLK_RECEIVE 3'h4
`define IDX_RESP_TOP 3'h3
`define IDX_TONE_BASE 3'h4
`endif

// *** include/coef_addr_pkg.sv ***
// types for the coefficient memory block addressing logic
package coef_addr_pkg;
    typedef enum logic [3:0] {
        region_impedance_filter_coeffs,
        region_echo_filter_coeffs,
        region_input_gain_coeffs,
        region_tone0_freq,
        region_tone0_amp,
        region_tone1_freq,
        region_tone1_amp,
        region_transmit_response_coeffs,
        region_transmit_gain_coeffs,
        region_receive_response_coeffs,
        region_receive_gain_coeffs,
        region_none
    } coef_region_t;
    typedef enum {st_idle, st_walk} walk_state_t;
endpackage

// *** dv/coef_block_addr_chk.sv ***
// port assertions for the coefficient block addressing logic
`timescale 1ns/100ps
module coef_block_addr_chk
    import coef_addr_pkg::*;
(
    // watched ports, grouped
    input wire logic core_clk_in, sys_rst_in, cmd_valid_in, cmd_ready_out, cmd_error_out,
    input wire logic busy_out, done_out, word_valid_in, word_ready_out,
    input wire logic [2:0] cmd_block_in, word_index_out,
    input wire logic [5:0] word_addr_out,
    input wire coef_region_t region_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // a command taken while idle
    wire take = cmd_valid_in && cmd_ready_out;
    wire step = busy_out && word_valid_in;
    a_bad_block: assert property (take && cmd_block_in > 4 |=> cmd_error_out && !busy_out)
        else $error("bad block not refused");
    a_walk_start: assert property (take && cmd_block_in <= 4 |=> busy_out
        && word_addr_out == {$past(cmd_block_in), 3'h7}) else $error("walk start wrong");
    a_index_down: assert property (step && word_index_out != 0
        |=> word_index_out == $past(word_index_out) - 3'h1) else $error("index not stepped");
    a_last_done: assert property (step && word_index_out == 0 |=> done_out && !busy_out)
        else $error("no done after last word");
    a_addr_form: assert property (busy_out |-> word_addr_out[2:0] == word_index_out)
        else $error("address low bits wrong");
    a_stall_hold: assert property (busy_out && !word_valid_in |=> $stable(word_addr_out))
        else $error("address moved on stall");
    a_busy_refuse: assert property (busy_out |-> word_ready_out && !cmd_ready_out)
        else $error("command open during walk");
    a_recv_pair: assert property (busy_out && word_addr_out[5:3] == 3'h4 |-> region_out ==
        (word_index_out[2] ? region_receive_gain_coeffs : region_receive_response_coeffs))
        else $error("receive region wrong");
endmodule // coef_block_addr_chk
bind coef_block_addr coef_block_addr_chk chk (.core_clk_in, .sys_rst_in, .cmd_valid_in,
    .cmd_ready_out, .cmd_error_out, .busy_out, .done_out, .word_valid_in, .word_ready_out,
    .cmd_block_in, .word_index_out, .word_addr_out, .region_out);

// *** dv/coef_host_model.sv ***
// host side: offers one word per step with random stalls
`timescale 1ns/100ps
`include "coef_addr_params.svh"
module coef_host_model (
    // clock and word handshake
    input wire logic core_clk_in,
    input wire logic word_ready_in,
    output logic word_valid_out = 1'b0
);
    // words already handed over in the walk in hand
    int taken = 0;
    // offers a word only while the walk is open, never beyond its eighth word
    always @(posedge core_clk_in) begin
        if (!word_ready_in)
            taken <= 0;
        else if (word_valid_out)
            taken <= taken + 1;
        word_valid_out <= word_ready_in && taken + int'(word_valid_out) < `COEF_BLOCK_WORDS
            && $urandom_range(3) != 0;
    end
endmodule // coef_host_model

// *** dv/coef_block_addr_tb_top.sv ***
// self-checking bench for the coefficient block addressing logic
`timescale 1ns/100ps
module coef_block_addr_tb_top;
    import coef_addr_pkg::*;
    logic core_clk_in = 0, sys_rst_in = 1, cmd_valid_in = 0, cmd_write_in = 0, word_valid_in;
    logic cmd_ready_out, cmd_error_out, word_ready_out, busy_out, done_out;
    logic [2:0] cmd_block_in = 0, word_index_out;
    logic [15:0] word_wdata_in = 0, word_rdata_out, mem [40];
    logic [5:0] word_addr_out;
    coef_region_t region_out;
    int n_mismatch = 0, checked = 0;
    // design and host model
    coef_block_addr dut (.core_clk_in, .sys_rst_in, .cmd_valid_in, .cmd_write_in,
        .cmd_block_in, .cmd_ready_out, .cmd_error_out, .word_valid_in, .word_wdata_in,
        .word_ready_out, .word_rdata_out, .word_index_out, .word_addr_out, .busy_out,
        .done_out, .region_out);
    coef_host_model host (.core_clk_in, .word_ready_in(word_ready_out),
        .word_valid_out(word_valid_in));
    // clock and random write data
    always #20 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) word_wdata_in <= 16'($urandom);
    function automatic coef_region_t exp_region(input int a);
        case (a / 8)
            0: return region_impedance_filter_coeffs;
            1: return region_echo_filter_coeffs;
            2: case (a % 8)
                4: return region_tone0_freq;
                5: return region_tone0_amp;
                6: return region_tone1_freq;
                7: return region_tone1_amp;
                default: return region_input_gain_coeffs;
            endcase
            3: return a % 8 < 4 ? region_transmit_response_coeffs : region_transmit_gain_coeffs;
            4: return a % 8 < 4 ? region_receive_response_coeffs : region_receive_gain_coeffs;
            default: return region_none;
        endcase
    endfunction
    // every comparison is counted; a mismatch prints one line
    task automatic tally(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        tally(16'(got), 16'(exp));
    endtask
    task automatic chk_addr(input logic [5:0] got, input logic [5:0] exp);
        tally(16'(got), 16'(exp));
    endtask
    task automatic chk_region(input coef_region_t got, input coef_region_t exp);
        tally(16'(got), 16'(exp));
    endtask
    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        tally(got, exp);
    endtask
    task automatic finish_test();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one command, then for blocks 0 to 4 the eight-word walk against the model
    task automatic run_block(input int b, input logic wr);
        int i;
        int a;
        i = 7;
        @(posedge core_clk_in);
        cmd_valid_in <= 1;
        cmd_block_in <= 3'(b);
        cmd_write_in <= wr;
        @(posedge core_clk_in);
        cmd_valid_in <= 0;
        #1;
        chk_flag(cmd_error_out, b > 4);
        chk_flag(busy_out, b <= 4);
        chk_flag(cmd_ready_out, b > 4);
        while (b <= 4 && i >= 0) begin
            if (word_valid_in && word_ready_out) begin
                a = b * 8 + i;
                chk_addr(word_addr_out, a);
                chk_addr(word_index_out, i);
                chk_region(region_out, exp_region(a));
                if (wr) mem[a] = word_wdata_in;
                else chk_data(word_rdata_out, mem[a]);
                i--;
            end
            @(posedge core_clk_in);
            #1;
        end
        if (b <= 4) chk_flag(done_out, 1);
        if (b <= 4) chk_flag(cmd_ready_out, 1);
        if (b <= 4) chk_region(region_out, region_none);
        $display("test block %0d write %0d done", b, wr);
    endtask
    initial begin
        void'($urandom(43513));
        repeat (3) @(posedge core_clk_in);
        sys_rst_in <= 0;
        #1;
        chk_flag(cmd_ready_out, 1);
        chk_flag(busy_out | done_out | cmd_error_out, 0);
        chk_addr(word_index_out, 0);
        chk_data(word_rdata_out, 0);
        chk_region(region_out, region_none);
        for (int p = 0; p < 2; p++) for (int b = 0; b < 8; b++) run_block(b, p == 0);
        finish_test();
    end
    // watchdog
    initial begin
        #400000;
        n_mismatch++;
        finish_test();
    end
endmodule // coef_block_addr_tb_top
